// ===== hw/load_ovp_regs.svh
// Register offsets, field positions, reset values and timing counts of the load overvoltage monitor.
`ifndef LOAD_OVP_REGS_SVH
`define LOAD_OVP_REGS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define LOV_IDX_LIMIT 8'h33
`define LOV_IDX_STATUS 8'h40
`define LOV_IDX_MASK 8'h41
`define LOV_IDX_STATE 8'h42

// Fields of the limit register.
`define LOV_CODE_MSB 7
`define LOV_CODE_LSB 3
`define LOV_REMOTE_BIT 2
`define LOV_SAMPLES_MSB 1
`define LOV_SAMPLES_LSB 0

// Status and mask bits.
`define LOV_ST_TRIP 0
`define LOV_ST_EXCEED 1
`define LOV_ST_WIDTH 2

// Reset values.
`define LOV_LIMIT_RESET 8'h00
`define LOV_MASK_RESET 2'b00

// Threshold = (offset + code) / 128 of the 1.55 V full scale.
`define LOV_THR_OFFSET 89
`define LOV_THR_STEPS_LOG2 7

// Sampling period in microseconds and the clock rate in MHz.
`define LOV_PERIOD_US 80
`define LOV_CLK_MHZ 40
`define LOV_PERIOD_CYCLES (`LOV_PERIOD_US * `LOV_CLK_MHZ)

// Longest run of exceeding periods that can be asked for.
`define LOV_RUN_MAX 3'd4

`endif

// ===== hw/load_ovp_pkg.sv
// Types shared by the load overvoltage monitor.
package load_ovp_pkg;
   typedef logic [4:0] ovp_code_t;
   typedef logic [1:0] samples_t;
   typedef logic [2:0] run_t;
   typedef struct packed {
      ovp_code_t code;
      logic remote;
      samples_t samples;
   } limit_s;
endpackage : load_ovp_pkg

// ===== hw/ovp_period_checker.sv
// Counts consecutive exceeding sampling periods and raises the overvoltage flag.
module ovp_period_checker
   import load_ovp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic period_end,
   input wire logic exceed,
   input wire samples_t samples,
   output logic ovp_level,
   output logic trip,
   output run_t run_count
);
`include "load_ovp_regs.svh"

   run_t run_q, run_d;
   logic level_q, level_d;
   logic trip_q, trip_d;

   always_comb begin
      run_d = run_q;
      level_d = level_q;
      trip_d = 1'b0;
      if (period_end) begin
         if (exceed) begin
            // Saturate so a long overvoltage cannot wrap back below the limit.
            run_d = (run_q == `LOV_RUN_MAX) ? run_q : run_q + 3'd1;
         end else begin
            run_d = 3'd0;
         end
         level_d = run_d > {1'b0, samples};
         trip_d = level_d & ~level_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 3'd0;
         level_q <= 1'b0;
         trip_q <= 1'b0;
      end else begin
         run_q <= run_d;
         level_q <= level_d;
         trip_q <= trip_d;
      end
   end

   assign ovp_level = level_q;
   assign trip = trip_q;
   assign run_count = run_q;

   property p_broken_run;
      @(posedge sys_clk) disable iff (!rst_n)
      period_end && !exceed |=> run_q == 3'd0 && !level_q;
   endproperty
   a_broken_run: assert property (p_broken_run) else $error("run not cleared by a quiet period");

   property p_single_sample;
      @(posedge sys_clk) disable iff (!rst_n)
      period_end && exceed && samples == 2'b00 |=> level_q;
   endproperty
   a_single_sample: assert property (p_single_sample) else $error("one exceeding period did not flag");

   property p_run_needed;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(level_q) |-> run_q == {1'b0, samples} + 3'd1;
   endproperty
   a_run_needed: assert property (p_run_needed) else $error("flag rose at wrong run length");

   property p_not_early;
      @(posedge sys_clk) disable iff (!rst_n)
      period_end && exceed && run_q < {1'b0, samples} && !level_q |=> !level_q;
   endproperty
   a_not_early: assert property (p_not_early) else $error("flag raised before enough periods");

   property p_trip_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      trip_q |-> level_q ##1 !trip_q;
   endproperty
   a_trip_pulse: assert property (p_trip_pulse) else $error("trip is not a single pulse with the flag");

   c_four_run: cover property (@(posedge sys_clk) disable iff (!rst_n) samples == 2'b11 && $rose(level_q));
   c_broken: cover property (@(posedge sys_clk) disable iff (!rst_n) run_q == 3'd2 ##1 run_q == 3'd0);
endmodule : ovp_period_checker

// ===== hw/load_overvoltage_monitor.sv
// Load overvoltage monitor with its APB register file, sampling period timer and interrupt.
`include "load_ovp_regs.svh"
module load_overvoltage_monitor
   import load_ovp_pkg::*;
#(
   parameter int ADC_W = 12,
   parameter int PERIOD_CYCLES = `LOV_PERIOD_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ADC_W-1:0] load_sense_voltage_a,
   input wire logic [ADC_W-1:0] remote_load_sense_node,
   input wire logic soft_start_active,
   input wire logic output_isolation_switch_off,
   output logic period_strobe,
   output logic overvoltage_protection,
   output logic regulate_from_remote,
   output logic irq
);

   localparam int PCNT_W = $clog2(PERIOD_CYCLES);
   localparam logic [PCNT_W-1:0] PCNT_LAST = PCNT_W'(PERIOD_CYCLES - 1);
   localparam int THR_SHIFT = ADC_W - `LOV_THR_STEPS_LOG2;
   localparam logic [ADC_W-1:0] THR_OFFSET = ADC_W'(`LOV_THR_OFFSET);

   // Reset release through two flops; assertion stays asynchronous.
   logic rst_meta_q, rst_n;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // One-hot register select: limit, status, mask, state.
   function automatic logic [3:0] reg_sel(input logic [11:0] addr);
      logic [3:0] sel;
      sel = 4'b0000;
      if (addr[1:0] == 2'b00) begin
         case (addr[11:2])
            10'(`LOV_IDX_LIMIT): sel = 4'b0001;
            10'(`LOV_IDX_STATUS): sel = 4'b0010;
            10'(`LOV_IDX_MASK): sel = 4'b0100;
            10'(`LOV_IDX_STATE): sel = 4'b1000;
            default: sel = 4'b0000;
         endcase
      end
      return sel;
   endfunction : reg_sel

   limit_s limit_q, limit_d;
   logic [`LOV_ST_WIDTH-1:0] status_q, status_d, mask_q, mask_d;
   logic [31:0] rdata_q, rdata_d;
   logic [PCNT_W-1:0] pcnt_q, pcnt_d;
   logic remote_q, remote_d;
   logic [ADC_W-1:0] threshold;
   logic period_end, exceed_a, exceed_b, exceed;
   logic ovp_level, trip;
   run_t run_count;
   logic [3:0] sel;
   logic access, wr, rd;

   assign sel = reg_sel(paddr);
   assign access = psel & penable;
   assign wr = access & pwrite & (sel != 4'b0000);
   assign rd = access & ~pwrite;
   // Zero wait states: read data is prepared in the setup cycle.
   assign pready = 1'b1;
   assign pslverr = access & (sel == 4'b0000);

   // Threshold in ADC codes whose full scale stands for 1.55 V.
   assign threshold = (THR_OFFSET + ADC_W'(limit_q.code)) << THR_SHIFT;
   assign period_end = pcnt_q == PCNT_LAST;
   assign exceed_a = load_sense_voltage_a > threshold;
   assign exceed_b = remote_load_sense_node > threshold;
   assign exceed = exceed_a | exceed_b;

   always_comb begin
      pcnt_d = period_end ? '0 : pcnt_q + PCNT_W'(1);
      // Local sensing only while soft start or the isolation switch is off.
      remote_d = limit_q.remote | ~(soft_start_active | output_isolation_switch_off);
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcnt_q <= '0;
         remote_q <= 1'b0;
      end else begin
         pcnt_q <= pcnt_d;
         remote_q <= remote_d;
      end
   end

   ovp_period_checker u_checker (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .period_end(period_end),
      .exceed(exceed),
      .samples(limit_q.samples),
      .ovp_level(ovp_level),
      .trip(trip),
      .run_count(run_count)
   );

   always_comb begin
      logic [`LOV_ST_WIDTH-1:0] set;
      logic [`LOV_ST_WIDTH-1:0] clr;
      set = '0;
      clr = '0;
      limit_d = limit_q;
      mask_d = mask_q;
      rdata_d = rdata_q;
      set[`LOV_ST_TRIP] = trip;
      set[`LOV_ST_EXCEED] = period_end & exceed;
      if (wr && sel[0]) begin
         limit_d = limit_s'(pwdata[7:0]);
      end
      if (wr && sel[2]) begin
         mask_d = pwdata[`LOV_ST_WIDTH-1:0];
      end
      // A read clears only the bits it returned, so an event after the setup cycle waits for the next read.
      if (rd && sel[1]) begin
         clr = rdata_q[`LOV_ST_WIDTH-1:0];
      end
      status_d = (status_q & ~clr) | set;
      if (psel && !penable) begin
         case (sel)
            4'b0001: rdata_d = {24'h00_0000, limit_q};
            4'b0010: rdata_d = {30'h0000_0000, status_q};
            4'b0100: rdata_d = {30'h0000_0000, mask_q};
            4'b1000: rdata_d = {28'h000_0000, run_count, ovp_level};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         limit_q <= limit_s'(`LOV_LIMIT_RESET);
         status_q <= '0;
         mask_q <= `LOV_MASK_RESET;
         rdata_q <= 32'h0000_0000;
      end else begin
         limit_q <= limit_d;
         status_q <= status_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;
   assign period_strobe = period_end;
   assign overvoltage_protection = ovp_level;
   assign regulate_from_remote = remote_q;
   assign irq = |(status_q & mask_q);

   property p_threshold;
      @(posedge sys_clk) disable iff (!rst_n)
      threshold == ADC_W'((`LOV_THR_OFFSET + int'(limit_q.code)) * (2 ** THR_SHIFT));
   endproperty
   a_threshold: assert property (p_threshold) else $error("threshold does not follow the code");

   property p_range;
      @(posedge sys_clk) disable iff (!rst_n)
      (limit_q.code == 5'd0 -> threshold == ADC_W'(89 << THR_SHIFT)) &&
      (limit_q.code == 5'd31 -> threshold == ADC_W'(120 << THR_SHIFT));
   endproperty
   a_range: assert property (p_range) else $error("threshold end points wrong");

   property p_strict;
      @(posedge sys_clk) disable iff (!rst_n)
      period_end && load_sense_voltage_a == threshold && remote_load_sense_node <= threshold
         |=> !status_q[`LOV_ST_EXCEED] || $past(status_q[`LOV_ST_EXCEED]);
   endproperty
   a_strict: assert property (p_strict) else $error("equal voltage counted as exceeding");

   property p_period;
      @(posedge sys_clk) disable iff (!rst_n)
      period_end |=> !period_end && pcnt_q == PCNT_W'(0);
   endproperty
   a_period: assert property (p_period) else $error("sampling period not restarted");

   property p_period_len;
      @(posedge sys_clk) disable iff (!rst_n)
      pcnt_q < PCNT_LAST |-> !period_end;
   endproperty
   a_period_len: assert property (p_period_len) else $error("period ended early");

   property p_remote;
      @(posedge sys_clk) disable iff (!rst_n)
      limit_q.remote |=> regulate_from_remote;
   endproperty
   a_remote: assert property (p_remote) else $error("remote regulation not forced by bit 2");

   property p_local;
      @(posedge sys_clk) disable iff (!rst_n)
      !limit_q.remote && soft_start_active |=> !regulate_from_remote;
   endproperty
   a_local: assert property (p_local) else $error("soft start did not select local sense");

   property p_trip_sticky;
      @(posedge sys_clk) disable iff (!rst_n)
      trip |=> status_q[`LOV_ST_TRIP];
   endproperty
   a_trip_sticky: assert property (p_trip_sticky) else $error("trip event lost in status");

   c_trip_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
   c_read_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) rd && sel[1] && status_q != '0);
   c_local: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(regulate_from_remote));
endmodule : load_overvoltage_monitor

// ===== tb/sense_front_end.sv
// Model of the averaging front end that feeds both load sense channels.
module sense_front_end #(
   parameter int ADC_W = 12
)
(
   input wire logic period_strobe,
   input wire logic [ADC_W-1:0] avg_a,
   input wire logic [ADC_W-1:0] avg_r,
   output logic [ADC_W-1:0] load_sense_voltage_a,
   output logic [ADC_W-1:0] remote_load_sense_node
);
   timeunit 1ns;
   timeprecision 1ps;
   // The average is valid only in the strobe cycle; the inverse elsewhere exposes sampling at the wrong time.
   assign load_sense_voltage_a = period_strobe ? avg_a : ~avg_a;
   assign remote_load_sense_node = period_strobe ? avg_r : ~avg_r;
endmodule : sense_front_end

// ===== tb/tb_top.sv
// Self-checking bench of the load overvoltage monitor, driven over APB.
`include "load_ovp_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 8;
   localparam int SH = 12 - `LOV_THR_STEPS_LOG2;
   localparam logic [11:0] A_LIM = 12'(`LOV_IDX_LIMIT * 4);
   localparam logic [11:0] A_ST = 12'(`LOV_IDX_STATUS * 4);
   localparam logic [11:0] A_MSK = 12'(`LOV_IDX_MASK * 4);
   localparam logic [11:0] A_SS = 12'(`LOV_IDX_STATE * 4);
   localparam logic [11:0] A_BAD = 12'h3f0;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [11:0] avg_a = 12'h000;
   logic [11:0] avg_r = 12'h000;
   logic [11:0] sense_a;
   logic [11:0] sense_r;
   logic soft_start_active = 1'b0;
   logic output_isolation_switch_off = 1'b0;
   logic period_strobe;
   logic ovp;
   logic regulate_from_remote;
   logic irq;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int num_checks = 0;

   always #12.5 sys_clk = ~sys_clk;

   load_overvoltage_monitor #(.ADC_W(12), .PERIOD_CYCLES(PC)) dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .load_sense_voltage_a(sense_a), .remote_load_sense_node(sense_r),
      .soft_start_active(soft_start_active), .output_isolation_switch_off(output_isolation_switch_off),
      .period_strobe(period_strobe), .overvoltage_protection(ovp),
      .regulate_from_remote(regulate_from_remote), .irq(irq)
   );

   sense_front_end #(.ADC_W(12)) front_u (
      .period_strobe(period_strobe), .avg_a(avg_a), .avg_r(avg_r),
      .load_sense_voltage_a(sense_a), .remote_load_sense_node(sense_r)
   );

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (n == 50) errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Presents one period average and returns three cycles after the strobe that takes it.
   task automatic step(input logic [11:0] a, input logic [11:0] r);
      int n;
      @(posedge sys_clk);
      avg_a <= a;
      avg_r <= r;
      for (n = 0; n < 4 * PC; n++) begin
         @(negedge sys_clk);
         if (period_strobe === 1'b1) break;
      end
      if (n == 4 * PC) errors++;
      repeat (3) @(negedge sys_clk);
   endtask : step

   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   initial begin
      #200us;
      errors++;
      summarize();
   end

   initial begin
      int s;
      int k;
      int c;
      logic [11:0] t;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      apb(1'b0, A_LIM, 32'h0000_0000);
      chk("limit reset", 32'h0000_0000, rd);
      apb(1'b0, A_MSK, 32'h0000_0000);
      chk("mask reset", 32'h0000_0000, rd);
      apb(1'b0, A_SS, 32'h0000_0000);
      chk("state reset", 32'h0000_0000, rd);
      chk("irq reset", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, A_BAD, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      chk("unmapped data", 32'h0000_0000, rd);
      apb(1'b1, A_BAD, 32'h0000_00ff);
      chk("unmapped write error", 32'h0000_0001, {31'h0, err});
      apb(1'b1, A_LIM, 32'h0000_00ff);
      apb(1'b0, A_LIM, 32'h0000_0000);
      chk("limit readback", 32'h0000_00ff, rd);
      for (k = 0; k < 8; k++) begin
         apb(1'b1, A_LIM, 32'(k[2] ? 4 : 0));
         soft_start_active <= k[1];
         output_isolation_switch_off <= k[0];
         repeat (3) @(negedge sys_clk);
         chk("regulate remote", {31'h0, k[2] | ~(k[1] | k[0])}, {31'h0, regulate_from_remote});
      end
      // Codes 0, 10, 20 and 31 cover both ends of the threshold range, one per sampling count.
      for (s = 0; s < 4; s++) begin
         c = (s == 3) ? 31 : s * 10;
         t = 12'((`LOV_THR_OFFSET + c) << SH);
         apb(1'b1, A_LIM, 32'((c << 3) | s));
         step(12'h000, 12'h000);
         step(t, t);
         chk("equal level", 32'h0000_0000, {31'h0, ovp});
         for (k = 0; k <= s; k++) begin
            step(k[0] ? 12'h000 : t + 12'd1, k[0] ? t + 12'd1 : 12'h000);
            chk("flag after run", {31'h0, k == s}, {31'h0, ovp});
         end
      end
      step(12'h000, 12'h000);
      for (k = 0; k < 8; k++) begin
         step(k == 3 ? 12'h000 : t + 12'd1, 12'h000);
         chk("broken run", {31'h0, k == 7}, {31'h0, ovp});
      end
      t = 12'(`LOV_THR_OFFSET << SH);
      apb(1'b1, A_LIM, 32'h0000_0000);
      apb(1'b1, A_MSK, 32'h0000_0001);
      step(12'h000, 12'h000);
      apb(1'b0, A_ST, 32'h0000_0000);
      step(t + 12'd1, 12'h000);
      chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
      apb(1'b0, A_ST, 32'h0000_0000);
      chk("status trip", 32'h0000_0003, rd);
      @(negedge sys_clk);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, A_MSK, 32'h0000_0000);
      chk("mask readback", 32'h0000_0001, rd);
      apb(1'b1, A_MSK, 32'h0000_0000);
      step(12'h000, 12'h000);
      step(12'h000, t + 12'd1);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b0, A_SS, 32'h0000_0000);
      chk("state run", 32'h0000_0003, rd);
      apb(1'b0, A_ST, 32'h0000_0000);
      chk("status masked", 32'h0000_0003, rd);
      summarize();
   end
endmodule : tb_top
